// *** rfsq_pkg.sv ***
// Constants, encodings and types for the RF query interpreter.
// Assumes a 100 MHz core clock and a byte-level framer around it.
package rfsq_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int T1_NS = 320900;
	localparam int T1_CYCLES = (T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] CMD_SYSINFO = 8'h2B;
	localparam logic [7:0] CMD_SECSTAT = 8'h2C;

	localparam int FLAG_OPT_BIT = 6;
	localparam int FLAG_ADDR_BIT = 5;
	localparam int FLAG_PEXT_BIT = 3;

	localparam logic [7:0] RESP_OK = 8'h00;
	localparam logic [7:0] RESP_ERR = 8'h01;
	localparam logic [7:0] INFO_BASIC = 8'h0B;
	localparam logic [7:0] INFO_EXT = 8'h0F;
	localparam logic [7:0] MEM_BLK_SIZE = 8'h03;
	localparam logic [15:0] MEM_BLK_COUNT = 16'h01FF;
	localparam logic [7:0] ERR_OPTION = 8'h03;
	localparam logic [7:0] ERR_BLOCK = 8'h10;
	localparam logic [15:0] BLOCK_MAX = 16'h01FF;
	localparam logic [2:0] STATUS_RSVD = 3'h0;

	localparam logic [3:0] RX_FLAGS = 4'h0;
	localparam logic [3:0] RX_CMD = 4'h1;
	localparam logic [3:0] RX_UID = 4'h2;
	localparam logic [3:0] RX_UID_END = 4'h9;
	localparam logic [3:0] RX_PARAM_ADDR = 4'hA;
	localparam logic [3:0] RX_PARAM_NOADDR = 4'h2;
	localparam logic [3:0] RX_PARAM_LEN = 4'h4;
	localparam logic [3:0] RX_IDX_MAX = 4'hF;

	localparam logic [9:0] POS_INFO = 10'h001;
	localparam logic [9:0] POS_UID = 10'h002;
	localparam logic [9:0] POS_DSFID = 10'h00A;
	localparam logic [9:0] POS_AFI = 10'h00B;
	localparam logic [9:0] POS_IC_BASIC = 10'h00C;
	localparam logic [9:0] POS_MEM0 = 10'h00C;
	localparam logic [9:0] POS_MEM1 = 10'h00D;
	localparam logic [9:0] POS_MEM2 = 10'h00E;
	localparam logic [9:0] POS_IC_EXT = 10'h00F;
	localparam logic [9:0] LEN_SYS = 10'h00D;
	localparam logic [9:0] LEN_EXT = 10'h010;
	localparam logic [9:0] LEN_ERR = 10'h002;
	localparam logic [9:0] LEN_STAT_EXTRA = 10'h002;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RECV,
		ST_WAIT,
		ST_SOFS,
		ST_SEND
	} rfsq_state_t;

	typedef enum logic [1:0] {
		RK_SYS,
		RK_EXT,
		RK_STAT,
		RK_ERR
	} rfsq_kind_t;
endpackage

// *** rfsq_timer_if.sv ***
// Start and expiry of the reply turnaround timer.
// Assumes both ends run on the same core clock.
interface rfsq_timer_if;
	logic start;
	logic done;
	modport ctrl(output start, input done);
	modport timer(input start, output done);
endinterface

// *** rfsq_turnaround.sv ***
// Turnaround timer: one-cycle done pulse a fixed time after start.
// Assumes start is a one-cycle pulse on the core clock.
module rfsq_turnaround #(
	parameter int T1_CYCLES = rfsq_pkg::T1_CYCLES
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	rfsq_timer_if.timer tmr
);
	localparam int CW = $clog2(T1_CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(T1_CYCLES);
	localparam logic [CW-1:0] ONE = CW'(1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic done;
	logic next_done;

	always_comb begin
		next_count = count;
		next_done = 1'b0;
		if (tmr.start) begin
			next_count = LOAD;
		end else if (count == ONE) begin
			next_count = '0;
			next_done = 1'b1;
		end else if (count != '0) begin
			next_count = count - ONE;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= '0;
			done <= 1'b0;
		end else begin
			count <= next_count;
			done <= next_done;
		end
	end

	assign tmr.done = done;
endmodule

// *** rfsq_query.sv ***
// System information and block security status query interpreter.
// Assumes a framer that strips CRC, checks it, and reports bytes.
//
// Summary of operation
// - Command 2Bh answers system information
// - Option flag set gives error 03h
// - Accept addressed and non-addressed requests
// - Basic reply: 00h, 0Bh, UID, DSFID, AFI, IC
// - Extension flag adds memory size, flags 0Fh
// - Memory size: blocks-1 (two bytes), then block bytes-1
// - Busy mode: output low SOF to reply end
// - Write-progress mode: output stays released
// - Command 2Ch answers block security status
// - Block count field holds count minus one
// - Extension flag zero gives error reply
// - Block address wraps 01FFh to 0000h
// - Reply: flags then one status byte each
// - Bit 0 shows sector locked
// - Errors: 03h option, 10h block unavailable
// - Activity output same for status query
module rfsq_query #(
	parameter int T1_CYCLES = rfsq_pkg::T1_CYCLES,
	// Arbitrary IC reference value
	parameter logic [7:0] IC_REF = 8'h5A
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic rx_sof_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_eof_i,
	output logic tx_sof_o,
	output logic tx_valid_o,
	output logic [7:0] tx_byte_o,
	input wire logic tx_ready_i,
	output logic tx_eof_o,
	input wire logic [63:0] uid_i,
	input wire logic [7:0] dsfid_i,
	input wire logic [7:0] afi_i,
	output logic [8:0] sector_addr_o,
	input wire logic sector_lock_i,
	input wire logic [1:0] sector_pwd_i,
	input wire logic [1:0] sector_rw_i,
	input wire logic busy_mode_i,
	output logic rf_activity_output_o,
	output logic rf_activity_output_oe_n_o
);
	rfsq_pkg::rfsq_state_t state, next_state;
	rfsq_pkg::rfsq_kind_t kind, next_kind;
	logic [7:0] flags, next_flags;
	logic [7:0] cmd, next_cmd;
	logic [3:0] rx_idx, next_rx_idx;
	logic mismatch, next_mismatch;
	logic [15:0] first, next_first;
	logic [15:0] count, next_count;
	logic [7:0] err, next_err;
	logic [9:0] len, next_len;
	logic [9:0] tx_idx, next_tx_idx;
	logic [8:0] blk, next_blk;
	logic busy, next_busy;
	logic tx_sof, next_tx_sof;
	logic tx_eof, next_tx_eof;
	logic tx_valid, next_tx_valid;
	logic [7:0] tx_byte, next_tx_byte;
	logic [3:0] base;
	logic [3:0] p;
	logic [2:0] k;
	logic [7:0] ld_byte;
	logic ld_stat;
	logic [7:0] stat_byte;
	logic addressed;

	rfsq_timer_if tmr();

	rfsq_turnaround #(.T1_CYCLES(T1_CYCLES)) u_turnaround (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.tmr(tmr)
	);

	assign addressed = flags[rfsq_pkg::FLAG_ADDR_BIT];
	assign base = addressed ? rfsq_pkg::RX_PARAM_ADDR :
		rfsq_pkg::RX_PARAM_NOADDR;
	assign p = rx_idx - base;
	assign stat_byte = {rfsq_pkg::STATUS_RSVD, sector_pwd_i, sector_rw_i,
		sector_lock_i};

	// Reply byte at position tx_idx
	always_comb begin
		k = 3'(tx_idx - rfsq_pkg::POS_UID);
		ld_byte = rfsq_pkg::RESP_OK;
		ld_stat = 1'b0;
		unique case (kind)
			rfsq_pkg::RK_ERR: begin
				ld_byte = (tx_idx == '0) ? rfsq_pkg::RESP_ERR : err;
			end
			rfsq_pkg::RK_STAT: begin
				if (tx_idx != '0) begin
					ld_byte = stat_byte;
					ld_stat = 1'b1;
				end
			end
			rfsq_pkg::RK_SYS, rfsq_pkg::RK_EXT: begin
				if (tx_idx == rfsq_pkg::POS_INFO) begin
					ld_byte = (kind == rfsq_pkg::RK_EXT) ?
						rfsq_pkg::INFO_EXT : rfsq_pkg::INFO_BASIC;
				end else if (tx_idx >= rfsq_pkg::POS_UID &&
						tx_idx < rfsq_pkg::POS_DSFID) begin
					ld_byte = uid_i[{k, 3'b000} +: 8];
				end else if (tx_idx == rfsq_pkg::POS_DSFID) begin
					ld_byte = dsfid_i;
				end else if (tx_idx == rfsq_pkg::POS_AFI) begin
					ld_byte = afi_i;
				end else if (kind == rfsq_pkg::RK_SYS) begin
					if (tx_idx == rfsq_pkg::POS_IC_BASIC) begin
						ld_byte = IC_REF;
					end
				end else if (tx_idx == rfsq_pkg::POS_MEM0) begin
					ld_byte = rfsq_pkg::MEM_BLK_COUNT[7:0];
				end else if (tx_idx == rfsq_pkg::POS_MEM1) begin
					ld_byte = rfsq_pkg::MEM_BLK_COUNT[15:8];
				end else if (tx_idx == rfsq_pkg::POS_MEM2) begin
					ld_byte = rfsq_pkg::MEM_BLK_SIZE;
				end else if (tx_idx == rfsq_pkg::POS_IC_EXT) begin
					ld_byte = IC_REF;
				end
			end
		endcase
	end

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_flags = flags;
		next_cmd = cmd;
		next_rx_idx = rx_idx;
		next_mismatch = mismatch;
		next_first = first;
		next_count = count;
		next_err = err;
		next_len = len;
		next_tx_idx = tx_idx;
		next_blk = blk;
		next_busy = busy;
		next_tx_sof = 1'b0;
		next_tx_eof = 1'b0;
		next_tx_valid = tx_valid;
		next_tx_byte = tx_byte;
		tmr.start = 1'b0;
		unique case (state)
			rfsq_pkg::ST_IDLE, rfsq_pkg::ST_RECV: begin
				if (rx_sof_i) begin
					next_state = rfsq_pkg::ST_RECV;
					next_busy = 1'b1;
					next_rx_idx = '0;
					next_mismatch = 1'b0;
				end else if (state == rfsq_pkg::ST_RECV && rx_eof_i) begin
					next_state = rfsq_pkg::ST_IDLE;
					next_busy = 1'b0;
					if (!mismatch && rx_idx >= base &&
							(cmd == rfsq_pkg::CMD_SYSINFO ||
							rx_idx >= base + rfsq_pkg::RX_PARAM_LEN)) begin
						next_state = rfsq_pkg::ST_WAIT;
						next_busy = 1'b1;
						tmr.start = 1'b1;
						next_kind = rfsq_pkg::RK_ERR;
						next_len = rfsq_pkg::LEN_ERR;
						next_err = rfsq_pkg::ERR_OPTION;
						if (cmd == rfsq_pkg::CMD_SYSINFO) begin
							if (!flags[rfsq_pkg::FLAG_OPT_BIT]) begin
								if (flags[rfsq_pkg::FLAG_PEXT_BIT]) begin
									next_kind = rfsq_pkg::RK_EXT;
									next_len = rfsq_pkg::LEN_EXT;
								end else begin
									next_kind = rfsq_pkg::RK_SYS;
									next_len = rfsq_pkg::LEN_SYS;
								end
							end
						end else if (flags[rfsq_pkg::FLAG_PEXT_BIT]) begin
							if (first > rfsq_pkg::BLOCK_MAX ||
									count > rfsq_pkg::BLOCK_MAX) begin
								next_err = rfsq_pkg::ERR_BLOCK;
							end else begin
								next_kind = rfsq_pkg::RK_STAT;
								next_blk = first[8:0];
								next_len = count[9:0] +
									rfsq_pkg::LEN_STAT_EXTRA;
							end
						end
					end
				end else if (state == rfsq_pkg::ST_RECV && rx_valid_i) begin
					if (rx_idx != rfsq_pkg::RX_IDX_MAX) begin
						next_rx_idx = rx_idx + 4'h1;
					end
					if (rx_idx == rfsq_pkg::RX_FLAGS) begin
						next_flags = rx_byte_i;
					end else if (rx_idx == rfsq_pkg::RX_CMD) begin
						next_cmd = rx_byte_i;
						if (rx_byte_i != rfsq_pkg::CMD_SYSINFO &&
								rx_byte_i != rfsq_pkg::CMD_SECSTAT) begin
							next_state = rfsq_pkg::ST_IDLE;
							next_busy = 1'b0;
						end
					end else if (addressed && rx_idx <= rfsq_pkg::RX_UID_END) begin
						if (rx_byte_i != uid_i[{3'(rx_idx - rfsq_pkg::RX_UID),
								3'b000} +: 8]) begin
							next_mismatch = 1'b1;
						end
					end else if (p < 4'h2) begin
						next_first = {rx_byte_i, first[15:8]};
					end else if (p < rfsq_pkg::RX_PARAM_LEN) begin
						next_count = {rx_byte_i, count[15:8]};
					end
				end
			end
			rfsq_pkg::ST_WAIT: begin
				if (tmr.done) begin
					next_state = rfsq_pkg::ST_SOFS;
					next_tx_sof = 1'b1;
					next_tx_idx = '0;
				end
			end
			rfsq_pkg::ST_SOFS: begin
				next_state = rfsq_pkg::ST_SEND;
				next_tx_valid = 1'b1;
				next_tx_byte = ld_byte;
				next_tx_idx = tx_idx + 10'h001;
			end
			rfsq_pkg::ST_SEND: begin
				if (tx_ready_i) begin
					if (tx_idx == len) begin
						next_state = rfsq_pkg::ST_IDLE;
						next_tx_valid = 1'b0;
						next_tx_eof = 1'b1;
						next_busy = 1'b0;
					end else begin
						next_tx_byte = ld_byte;
						next_tx_idx = tx_idx + 10'h001;
						if (ld_stat) begin
							next_blk = blk + 9'h001;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= rfsq_pkg::ST_IDLE;
			kind <= rfsq_pkg::RK_ERR;
			flags <= 8'h00;
			cmd <= 8'h00;
			rx_idx <= 4'h0;
			mismatch <= 1'b0;
			first <= 16'h0000;
			count <= 16'h0000;
			err <= 8'h00;
			len <= 10'h000;
			tx_idx <= 10'h000;
			blk <= 9'h000;
			busy <= 1'b0;
			tx_sof <= 1'b0;
			tx_eof <= 1'b0;
			tx_valid <= 1'b0;
			tx_byte <= 8'h00;
		end else begin
			state <= next_state;
			kind <= next_kind;
			flags <= next_flags;
			cmd <= next_cmd;
			rx_idx <= next_rx_idx;
			mismatch <= next_mismatch;
			first <= next_first;
			count <= next_count;
			err <= next_err;
			len <= next_len;
			tx_idx <= next_tx_idx;
			blk <= next_blk;
			busy <= next_busy;
			tx_sof <= next_tx_sof;
			tx_eof <= next_tx_eof;
			tx_valid <= next_tx_valid;
			tx_byte <= next_tx_byte;
		end
	end

	assign tx_sof_o = tx_sof;
	assign tx_eof_o = tx_eof;
	assign tx_valid_o = tx_valid;
	assign tx_byte_o = tx_byte;
	assign sector_addr_o = blk;
	assign rf_activity_output_o = 1'b0;
	// Released unless busy mode and a query is in progress
	assign rf_activity_output_oe_n_o = ~(busy & busy_mode_i);
endmodule

// *** rfsq_query_monitor.sv ***
// Checker of reply timing and activity output of the query interpreter.
// Assumes one core clock and the interpreter's top-level ports.
module rfsq_query_monitor #(
	parameter int T1_CYCLES = rfsq_pkg::T1_CYCLES
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic rx_sof_i,
	input wire logic rx_eof_i,
	input wire logic tx_sof_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_byte_o,
	input wire logic tx_ready_i,
	input wire logic tx_eof_o,
	input wire logic busy_mode_i,
	input wire logic rf_activity_output_oe_n_o
);
	logic [31:0] since_eof;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	sequence s_take;
		tx_valid_o && tx_ready_i;
	endsequence
	sequence s_open;
		tx_sof_o ##1 tx_valid_o;
	endsequence
	// Cycles since the last request end
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			since_eof <= '1;
		end else if (rx_eof_i) begin
			since_eof <= '0;
		end else if (since_eof != '1) begin
			since_eof <= since_eof + 32'h1;
		end
	end
	a_turnaround_time: assert property (
		tx_sof_o |-> since_eof == T1_CYCLES + 1)
		else $error("reply start not at turnaround");
	a_reply_open: assert property (tx_sof_o |-> s_open)
		else $error("no byte after reply start");
	a_byte_held: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
		else $error("reply byte dropped while stalled");
	a_end_after_take: assert property (
		s_take ##1 !tx_valid_o |-> tx_eof_o)
		else $error("reply end missing");
	a_end_cause: assert property (
		tx_eof_o |-> !tx_valid_o && $past(tx_valid_o && tx_ready_i))
		else $error("reply end without last byte");
	a_busy_start: assert property (
		busy_mode_i && rx_sof_i |=> !rf_activity_output_oe_n_o)
		else $error("busy not driven after request start");
	a_busy_hold: assert property (
		busy_mode_i && tx_valid_o |-> !rf_activity_output_oe_n_o)
		else $error("busy released during reply");
	a_busy_release: assert property (
		tx_eof_o |-> rf_activity_output_oe_n_o)
		else $error("busy held after reply end");
	a_wip_released: assert property (
		!busy_mode_i |-> rf_activity_output_oe_n_o)
		else $error("activity output driven in write mode");
endmodule
bind rfsq_query rfsq_query_monitor #(.T1_CYCLES(T1_CYCLES))
	rfsq_query_monitor_inst (.clock_i, .arst_n_i, .rx_sof_i, .rx_eof_i,
	.tx_sof_o, .tx_valid_o, .tx_byte_o, .tx_ready_i, .tx_eof_o,
	.busy_mode_i, .rf_activity_output_oe_n_o);

// *** rfsq_reader.sv ***
// Reader-side framer model: sends request bytes, takes reply bytes.
// Assumes requests are issued only while the interpreter is idle.
module rfsq_reader (
	input wire logic clock_i,
	input wire logic slow_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_eof_i,
	output logic rx_sof_o,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic rx_eof_o,
	output logic tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	logic done;
	initial begin
		{rx_sof_o, rx_valid_o, rx_eof_o, done} = '0;
		rx_byte_o = 8'h00;
		tx_ready_o = 1'b1;
	end
	// Stalls every other cycle when slow
	always @(negedge clock_i) begin
		tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
	end
	always @(posedge clock_i) begin
		if (tx_valid_i && tx_ready_o)
			got.push_back(tx_byte_i);
		if (tx_eof_i)
			done <= 1'b1;
	end
	// Start, bytes in order, end; data line scrambled after release
	task automatic send(input logic [7:0] q[$]);
		@(negedge clock_i) rx_sof_o = 1'b1;
		foreach (q[i]) begin
			@(negedge clock_i);
			{rx_sof_o, rx_valid_o, rx_byte_o} = {2'b01, q[i]};
		end
		@(negedge clock_i);
		{rx_valid_o, rx_eof_o, rx_byte_o} = {2'b01, ~rx_byte_o};
		@(negedge clock_i) rx_eof_o = 1'b0;
	endtask
endmodule

// *** tb.sv ***
// Self-checking bench of the query interpreter with a reader model.
// Assumes the sector status stand-in answers combinationally.
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T1 = 20;
	localparam logic [63:0] UID = 64'h8877665544332211;
	// Arbitrary IC reference value
	localparam logic [7:0] ICR = 8'h3C;
	// Reset state: only the activity enable stands high
	localparam logic [20:0] RST_OUT = 21'h020000;
	typedef struct {
		logic [7:0] fl;
		logic [7:0] cmd;
		logic [15:0] fst;
		logic [15:0] cnt;
		logic bz;
		int len;
	} rfsq_row_t;
	logic clock_i, arst_n_i, rx_sof_i, rx_valid_i, rx_eof_i, slow;
	logic tx_sof_o, tx_valid_o, tx_ready_i, tx_eof_o, busy_mode_i;
	logic [7:0] tx_byte_o, rx_byte_i, dsfid_i, afi_i;
	logic [63:0] uid_i;
	logic [8:0] sector_addr_o;
	logic [1:0] sector_pwd_i, sector_rw_i;
	logic sector_lock_i, rf_activity_output_o, rf_activity_output_oe_n_o;
	logic [20:0] outs;
	int n_fail = 0;
	int n_tests = 0;
	rfsq_row_t rows[8] = '{
		'{8'h02, 8'h2B, 16'h0000, 16'h0000, 1'b1, 13},
		'{8'h2A, 8'h2B, 16'h0000, 16'h0000, 1'b1, 16},
		'{8'h42, 8'h2B, 16'h0000, 16'h0000, 1'b1, 2},
		'{8'h0A, 8'h2C, 16'h0010, 16'h0006, 1'b1, 8},
		'{8'h02, 8'h2C, 16'h0000, 16'h0000, 1'b0, 2},
		'{8'h0A, 8'h2C, 16'h01FE, 16'h0003, 1'b1, 5},
		'{8'h0A, 8'h2C, 16'h0200, 16'h0000, 1'b1, 2},
		'{8'h0A, 8'h2B, 16'h0000, 16'h0000, 1'b0, 16}
	};
	rfsq_query #(.T1_CYCLES(T1), .IC_REF(ICR)) rfsq_query_inst (
		.clock_i, .arst_n_i, .rx_sof_i, .rx_valid_i, .rx_byte_i, .rx_eof_i,
		.tx_sof_o, .tx_valid_o, .tx_byte_o, .tx_ready_i, .tx_eof_o, .uid_i,
		.dsfid_i, .afi_i, .sector_addr_o, .sector_lock_i, .sector_pwd_i,
		.sector_rw_i, .busy_mode_i, .rf_activity_output_o,
		.rf_activity_output_oe_n_o);
	rfsq_reader rfsq_reader_inst (.clock_i, .slow_i(slow),
		.tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .tx_eof_i(tx_eof_o),
		.rx_sof_o(rx_sof_i), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i),
		.rx_eof_o(rx_eof_i), .tx_ready_o(tx_ready_i));
	// Sector status stand-in: password, protection, lock
	function automatic logic [4:0] sec(input logic [8:0] a);
		return {a[2:1], a[4:3], a[0] ^ a[5]};
	endfunction
	assign {sector_pwd_i, sector_rw_i, sector_lock_i} = sec(sector_addr_o);
	assign outs = {tx_sof_o, tx_valid_o, tx_eof_o, rf_activity_output_oe_n_o,
		sector_addr_o, tx_byte_o};
	task automatic run(input rfsq_row_t r);
		logic [7:0] q[$];
		logic [7:0] e[$];
		int w;
		q = {r.fl, r.cmd};
		e = {8'h01, 8'h03};
		for (int i = 0; i < 8; i++)
			if (r.fl[5]) q.push_back(UID[8*i +: 8]);
		if (r.cmd == 8'h2C)
			q = {q, r.fst[7:0], r.fst[15:8], r.cnt[7:0], r.cnt[15:8]};
		if (r.cmd == 8'h2C && r.fl[3]) begin
			e = {8'h00};
			for (int i = 0; i <= r.cnt; i++)
				e.push_back({3'h0, sec(9'(r.fst + i))});
			if (r.fst > 16'h01FF || r.cnt > 16'h01FF)
				e = {8'h01, 8'h10};
		end
		if (r.cmd == 8'h2B && !r.fl[6]) begin
			e = {8'h00, r.fl[3] ? 8'h0F : 8'h0B};
			for (int i = 0; i < 8; i++)
				e.push_back(UID[8*i +: 8]);
			e = {e, dsfid_i, afi_i};
			if (r.fl[3])
				e = {e, 8'hFF, 8'h01, 8'h03};
			e.push_back(ICR);
		end
		if (r.len == 0)
			e.delete();
		busy_mode_i = r.bz;
		rfsq_reader_inst.done = 1'b0;
		rfsq_reader_inst.got.delete();
		rfsq_reader_inst.send(q);
		`CHK("busy", !r.bz, rf_activity_output_oe_n_o)
		`CHK("act", 1'b0, rf_activity_output_o)
		for (w = 0; w < 2000 && !rfsq_reader_inst.done; w++)
			@(posedge clock_i);
		@(negedge clock_i);
		`CHK("done", r.len != 0, rfsq_reader_inst.done)
		`CHK("oe_end", 1'b1, rf_activity_output_oe_n_o)
		`CHK("len", r.len, rfsq_reader_inst.got.size())
		foreach (e[i])
			`CHK("byte", e[i], rfsq_reader_inst.got[i])
	endtask
	// Reset while waiting to reply: no reply may follow
	task automatic reset_mid();
		logic [7:0] q[$];
		q = {8'h02, 8'h2B};
		busy_mode_i = 1'b1;
		rfsq_reader_inst.done = 1'b0;
		rfsq_reader_inst.send(q);
		repeat (5) @(negedge clock_i);
		arst_n_i = 1'b0;
		@(negedge clock_i);
		`CHK("mid_reset", RST_OUT, outs)
		arst_n_i = 1'b1;
		repeat (T1 + 40) @(negedge clock_i);
		`CHK("no_reply", 1'b0, rfsq_reader_inst.done)
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = !clock_i;
	end
	initial begin
		{arst_n_i, busy_mode_i, slow} = '0;
		uid_i = UID;
		dsfid_i = 8'hD5;
		afi_i = 8'hA7;
		repeat (20) @(negedge clock_i);
		`CHK("reset", RST_OUT, outs)
		arst_n_i = 1'b1;
		foreach (rows[i]) begin
			slow = i[0];
			run(rows[i]);
		end
		reset_mid();
		run(rows[3]);
		uid_i = ~UID;
		run('{8'h22, 8'h2B, 16'h0000, 16'h0000, 1'b0, 0});
		stop_test();
	end
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
	task automatic stop_test();
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
endmodule
